// file: design/audio_pin_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// RQ1 - hf rx clock input feeds the receiver
// RQ2 - hf rx clock output drives sample clock
// RQ3 - hf tx clock input feeds the transmitter
// RQ4 - hf tx clock output drives sample clock
// RQ5 - async mode: rx frame-sync pin serves receivers
// RQ6 - sync mode, no buffer enable: flag one
// RQ7 - sync, buffer enable, output: drive buffer enable
// RQ8 - flag direction follows rx frame-sync direction
// RQ9 - output flag updates at frame or slot
// RQ10 - input flag sampled at frame or slot
// RQ11 - sync mode: tx frame sync shared by all
// RQ12 - async mode: tx frame sync for transmitters only
// RQ13 - tx frame-sync direction bit sets pin direction
// RQ14 - general-purpose pins: input, output or off
// RQ15 - reset leaves every pin disconnected
// RQ16 - exactly one function drives each pin
module audio_pin_ctrl #(
    parameter int HF_HALF = audio_pin_pkg::HF_HALF_DEF
) (
    // core clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // serial link clock
    input  wire logic       clk_link,
    // pin function and general-purpose setup, core domain
    input  wire logic [3:0] pin_serial_sel,
    input  wire logic [7:0] gpio_dir,
    input  wire logic [3:0] gpio_out,
    output logic      [3:0] gpio_in,
    // serial unit configuration, core domain
    input  wire logic       hck_rx_dir,
    input  wire logic       hck_tx_dir,
    input  wire logic       shared_clocking_select,
    input  wire logic       tx_ext_buffer_enable_select,
    input  wire logic       rx_fs_direction,
    input  wire logic       tx_fs_direction,
    input  wire logic       network_mode,
    input  wire logic       serial_out_flag_one,
    // status, core domain
    output logic            serial_in_flag_one,
    output logic            rx_clk_from_pin,
    output logic            tx_clk_from_pin,
    // serial unit side, link domain
    input  wire logic       rx_fs_gen,
    input  wire logic       tx_fs_gen,
    input  wire logic       slot_start,
    input  wire logic       tx_buf_en_req,
    output logic            rx_fs_recv,
    output logic            tx_fs_xmit,
    // receiver high-frequency clock pin
    input  wire logic       rx_high_freq_clock_pin_i,
    output logic            rx_high_freq_clock_pin_o,
    output logic            rx_high_freq_clock_pin_oe,
    // transmitter high-frequency clock pin
    input  wire logic       tx_high_freq_clock_pin_i,
    output logic            tx_high_freq_clock_pin_o,
    output logic            tx_high_freq_clock_pin_oe,
    // receiver frame-sync pin
    input  wire logic       rx_frame_sync_pin_i,
    output logic            rx_frame_sync_pin_o,
    output logic            rx_frame_sync_pin_oe,
    // transmitter frame-sync pin
    input  wire logic       tx_frame_sync_pin_i,
    output logic            tx_frame_sync_pin_o,
    output logic            tx_frame_sync_pin_oe
);

    // one owner per pin: serial function or general-purpose, never both
    function automatic logic [1:0] pin_drive(
        input logic       serial,
        input logic       ser_oe,
        input logic       ser_o,
        input logic [1:0] dir,
        input logic       gout
    );
        logic [1:0] res;
        res = {audio_pin_pkg::RST_OE, audio_pin_pkg::RST_LEVEL};
        if (serial) begin
            res = {ser_oe, ser_o & ser_oe};
        end else if (dir == audio_pin_pkg::GPIO_OUT) begin
            res = {1'b1, gout};
        end
        return res;
    endfunction

    // core domain: hf clock pins and general-purpose reads
    logic       hf_clk;
    logic [3:0] pin_in_s;
    logic [1:0] hck_rx_drv;
    logic [1:0] hck_tx_drv;

    hf_clock_gen #(
        .HALF      (HF_HALF)
    ) u_hf_clock_gen (
        .clk       (clk_sys),
        .rst_n     (rst_n),
        .clk_div_r (hf_clk)
    );

    // all four pins sampled for general-purpose reads
    level_sync #(
        .WIDTH (audio_pin_pkg::PIN_COUNT)
    ) u_pin_sync_sys (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     ({tx_frame_sync_pin_i, rx_frame_sync_pin_i,
                 tx_high_freq_clock_pin_i, rx_high_freq_clock_pin_i}),
        .q     (pin_in_s)
    );

    assign hck_rx_drv = pin_drive(pin_serial_sel[audio_pin_pkg::PIN_RX_HF], hck_rx_dir, hf_clk,
                                  gpio_dir[2*audio_pin_pkg::PIN_RX_HF +: 2], gpio_out[audio_pin_pkg::PIN_RX_HF]);
    assign hck_tx_drv = pin_drive(pin_serial_sel[audio_pin_pkg::PIN_TX_HF], hck_tx_dir, hf_clk,
                                  gpio_dir[2*audio_pin_pkg::PIN_TX_HF +: 2], gpio_out[audio_pin_pkg::PIN_TX_HF]);

    // high-frequency clock pins: sample clock out, or source select in
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_high_freq_clock_pin_oe <= audio_pin_pkg::RST_OE;     // see RQ15
            rx_high_freq_clock_pin_o  <= audio_pin_pkg::RST_LEVEL;
            tx_high_freq_clock_pin_oe <= audio_pin_pkg::RST_OE;
            tx_high_freq_clock_pin_o  <= audio_pin_pkg::RST_LEVEL;
            rx_clk_from_pin           <= 1'b0;
            tx_clk_from_pin           <= 1'b0;
        end else begin
            {rx_high_freq_clock_pin_oe, rx_high_freq_clock_pin_o} <= hck_rx_drv;   // see RQ2 see RQ16
            {tx_high_freq_clock_pin_oe, tx_high_freq_clock_pin_o} <= hck_tx_drv;   // see RQ4
            rx_clk_from_pin <= pin_serial_sel[audio_pin_pkg::PIN_RX_HF] & ~hck_rx_dir; // see RQ1
            tx_clk_from_pin <= pin_serial_sel[audio_pin_pkg::PIN_TX_HF] & ~hck_tx_dir; // see RQ3
        end
    end

    // general-purpose reads: a disconnected or serial pin reads zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gpio_in <= '0;
        end else begin
            for (int i = 0; i < audio_pin_pkg::PIN_COUNT; i++) begin
                gpio_in[i] <= ~pin_serial_sel[i] && gpio_dir[2*i +: 2] == audio_pin_pkg::GPIO_IN
                              && pin_in_s[i];                        // see RQ14
            end
        end
    end

    // link domain: frame-sync pins and flag one
    logic                            link_rst_meta_r;
    logic                            link_rst_n;
    logic [audio_pin_pkg::CFG_WIDTH-1:0] cfg_word;
    logic [audio_pin_pkg::CFG_WIDTH-1:0] cfg_s;
    logic [1:0]                      fs_pin_s;
    logic                            if1_r;
    logic                            of1_r;
    logic                            fs_prev_r;
    logic                            fs_sel;
    logic                            upd;
    logic                            syn_s;
    logic                            rx_fs_direction_s;
    logic                            tx_fs_direction_s;
    audio_pin_pkg::rx_fs_role_t      role;
    logic [1:0]                      rx_fs_drv;
    logic [1:0]                      tx_fs_drv;
    logic                            rx_ser_oe;
    logic                            rx_ser_o;

    // release of reset made synchronous to the link clock
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            link_rst_meta_r <= 1'b0;
            link_rst_n      <= 1'b0;
        end else begin
            link_rst_meta_r <= 1'b1;
            link_rst_n      <= link_rst_meta_r;
        end
    end

    // quasi-static setup: change it only while the link is idle
    assign cfg_word = {serial_out_flag_one, network_mode, tx_fs_direction, rx_fs_direction,
                       tx_ext_buffer_enable_select, shared_clocking_select,
                       gpio_out[audio_pin_pkg::PIN_TX_FS], gpio_out[audio_pin_pkg::PIN_RX_FS],
                       gpio_dir[2*audio_pin_pkg::PIN_TX_FS +: 2], gpio_dir[2*audio_pin_pkg::PIN_RX_FS +: 2],
                       pin_serial_sel[audio_pin_pkg::PIN_TX_FS], pin_serial_sel[audio_pin_pkg::PIN_RX_FS]};

    level_sync #(
        .WIDTH (audio_pin_pkg::CFG_WIDTH)
    ) u_cfg_sync (
        .clk   (clk_link),
        .rst_n (link_rst_n),
        .d     (cfg_word),
        .q     (cfg_s)
    );

    level_sync #(
        .WIDTH (2)
    ) u_fs_pin_sync (
        .clk   (clk_link),
        .rst_n (link_rst_n),
        .d     ({tx_frame_sync_pin_i, rx_frame_sync_pin_i}),
        .q     (fs_pin_s)
    );

    assign syn_s  = cfg_s[audio_pin_pkg::CFG_SYN];
    assign rx_fs_direction_s = cfg_s[audio_pin_pkg::CFG_RX_FS_DIRECTION];
    assign tx_fs_direction_s = cfg_s[audio_pin_pkg::CFG_TX_FS_DIRECTION];

    // shared frame: own generator when output, pin when input
    assign fs_sel = tx_fs_direction_s ? tx_fs_gen : fs_pin_s[1];                     // see RQ13
    assign upd    = cfg_s[audio_pin_pkg::CFG_NETWORK] ? slot_start : (fs_sel & ~fs_prev_r);

    // receiver frame-sync pin function
    always_comb begin
        if (!cfg_s[audio_pin_pkg::CFG_SER_RX_FS]) begin
            role = audio_pin_pkg::ROLE_GPIO;
        end else if (!syn_s) begin
            role = audio_pin_pkg::ROLE_FS;                                  // see RQ5
        end else if (cfg_s[audio_pin_pkg::CFG_TX_EXT_BUFFER_ENABLE_SELECT] && rx_fs_direction_s) begin
            role = audio_pin_pkg::ROLE_BUFEN;                               // see RQ7
        end else begin
            role = audio_pin_pkg::ROLE_FLAG;                                // see RQ6
        end
    end

    always_comb begin
        rx_ser_oe = rx_fs_direction_s;                                                 // see RQ8
        rx_ser_o  = 1'b0;
        unique case (role)
            audio_pin_pkg::ROLE_GPIO:  rx_ser_o = 1'b0;
            audio_pin_pkg::ROLE_FS:    rx_ser_o = rx_fs_gen;
            audio_pin_pkg::ROLE_FLAG:  rx_ser_o = of1_r;                    // see RQ9
            audio_pin_pkg::ROLE_BUFEN: rx_ser_o = tx_buf_en_req;
        endcase
    end

    assign rx_fs_drv = pin_drive(role != audio_pin_pkg::ROLE_GPIO, rx_ser_oe, rx_ser_o,
                                 cfg_s[audio_pin_pkg::CFG_DIR_RX_FS +: 2], cfg_s[audio_pin_pkg::CFG_GOUT_RX_FS]);
    assign tx_fs_drv = pin_drive(cfg_s[audio_pin_pkg::CFG_SER_TX_FS], tx_fs_direction_s, tx_fs_gen,
                                 cfg_s[audio_pin_pkg::CFG_DIR_TX_FS +: 2], cfg_s[audio_pin_pkg::CFG_GOUT_TX_FS]);

    // frame-sync pin drivers
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_frame_sync_pin_oe <= audio_pin_pkg::RST_OE;                  // see RQ15
            rx_frame_sync_pin_o  <= audio_pin_pkg::RST_LEVEL;
            tx_frame_sync_pin_oe <= audio_pin_pkg::RST_OE;
            tx_frame_sync_pin_o  <= audio_pin_pkg::RST_LEVEL;
        end else begin
            {rx_frame_sync_pin_oe, rx_frame_sync_pin_o} <= rx_fs_drv;       // see RQ16
            {tx_frame_sync_pin_oe, tx_frame_sync_pin_o} <= tx_fs_drv;       // see RQ13
        end
    end

    // frame syncs handed to receivers and transmitters
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_fs_recv <= 1'b0;
            tx_fs_xmit <= 1'b0;
            fs_prev_r  <= 1'b0;
        end else begin
            tx_fs_xmit <= fs_sel;                                           // see RQ12
            rx_fs_recv <= syn_s ? fs_sel : (rx_fs_direction_s ? rx_fs_gen : fs_pin_s[0]); // see RQ11 see RQ5
            fs_prev_r  <= fs_sel;
        end
    end

    // flag one: output held between updates, input sampled at updates
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            of1_r <= 1'b0;
            if1_r <= 1'b0;
        end else if (upd) begin
            of1_r <= cfg_s[audio_pin_pkg::CFG_OF1];                         // see RQ9
            if (role == audio_pin_pkg::ROLE_FLAG && !rx_fs_direction_s) begin
                if1_r <= fs_pin_s[0];                                       // see RQ10
            end
        end
    end

    level_sync #(
        .WIDTH (1)
    ) u_if1_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (if1_r),
        .q     (serial_in_flag_one)
    );

    initial begin
        if (HF_HALF < 1) begin
            $error("audio_pin_ctrl: HF_HALF must be at least 1");
        end
    end

    // checks next to the pin logic
    property p_hck_rx_out;
        @(posedge clk_sys) disable iff (!rst_n)
        pin_serial_sel[0] && hck_rx_dir |=> rx_high_freq_clock_pin_oe && !rx_clk_from_pin;
    endproperty
    a_hck_rx_out: assert property (p_hck_rx_out) else $error("rx hf clock not driven"); // see RQ2

    property p_hck_rx_in;
        @(posedge clk_sys) disable iff (!rst_n)
        pin_serial_sel[0] && !hck_rx_dir |=> rx_clk_from_pin && !rx_high_freq_clock_pin_oe;
    endproperty
    a_hck_rx_in: assert property (p_hck_rx_in) else $error("rx hf clock source wrong"); // see RQ1

    property p_hck_tx_in;
        @(posedge clk_sys) disable iff (!rst_n)
        pin_serial_sel[1] && !hck_tx_dir |=> tx_clk_from_pin && !tx_high_freq_clock_pin_oe;
    endproperty
    a_hck_tx_in: assert property (p_hck_tx_in) else $error("tx hf clock source wrong"); // see RQ3

    property p_hck_tx_out;
        @(posedge clk_sys) disable iff (!rst_n)
        pin_serial_sel[1] && hck_tx_dir && $stable(hf_clk) |=> tx_high_freq_clock_pin_o == $past(hf_clk);
    endproperty
    a_hck_tx_out: assert property (p_hck_tx_out) else $error("tx hf clock level wrong"); // see RQ4

    property p_gpio_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !pin_serial_sel[0] && gpio_dir[1:0] == audio_pin_pkg::GPIO_OFF |=> !rx_high_freq_clock_pin_oe;
    endproperty
    a_gpio_off: assert property (p_gpio_off) else $error("disconnected pin driven"); // see RQ14

    property p_flag_out;
        @(posedge clk_link) disable iff (!link_rst_n)
        role == audio_pin_pkg::ROLE_FLAG && rx_fs_direction_s |=> rx_frame_sync_pin_oe && rx_frame_sync_pin_o == $past(of1_r);
    endproperty
    a_flag_out: assert property (p_flag_out) else $error("output flag not on pin"); // see RQ9

    property p_flag_in;
        @(posedge clk_link) disable iff (!link_rst_n)
        upd && role == audio_pin_pkg::ROLE_FLAG && !rx_fs_direction_s |=> if1_r == $past(fs_pin_s[0]) && !rx_frame_sync_pin_oe;
    endproperty
    a_flag_in: assert property (p_flag_in) else $error("input flag not sampled"); // see RQ10

    property p_bufen;
        @(posedge clk_link) disable iff (!link_rst_n)
        role == audio_pin_pkg::ROLE_BUFEN |=> rx_frame_sync_pin_oe && rx_frame_sync_pin_o == $past(tx_buf_en_req);
    endproperty
    a_bufen: assert property (p_bufen) else $error("buffer enable not driven"); // see RQ7

    property p_shared_fs;
        @(posedge clk_link) disable iff (!link_rst_n)
        syn_s |=> rx_fs_recv == $past(fs_sel) && tx_fs_xmit == $past(fs_sel);
    endproperty
    a_shared_fs: assert property (p_shared_fs) else $error("frame sync not shared"); // see RQ11

    c_flag_update: cover property (@(posedge clk_link) disable iff (!link_rst_n)
        upd && role == audio_pin_pkg::ROLE_FLAG);
    c_bufen: cover property (@(posedge clk_link) disable iff (!link_rst_n)
        role == audio_pin_pkg::ROLE_BUFEN ##1 rx_frame_sync_pin_o);
    c_hck_out: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rx_high_freq_clock_pin_oe ##1 $changed(rx_high_freq_clock_pin_o));

endmodule

// file: design/audio_pin_pkg.sv
package audio_pin_pkg;

    // pin positions inside the per-pin vectors
    localparam int PIN_RX_HF = 0;
    localparam int PIN_TX_HF = 1;
    localparam int PIN_RX_FS = 2;
    localparam int PIN_TX_FS = 3;
    localparam int PIN_COUNT = 4;

    // general-purpose direction codes, two bits per pin
    localparam logic [1:0] GPIO_OFF = 2'h0;
    localparam logic [1:0] GPIO_IN  = 2'h1;
    localparam logic [1:0] GPIO_OUT = 2'h2;

    // reset values of the pin drivers
    localparam logic RST_OE    = 1'b0;
    localparam logic RST_LEVEL = 1'b0;

    // sample clock divider: half period in core clock cycles
    localparam int HF_HALF_DEF = 1;

    // synchroniser depth in front of any logic
    localparam int SYNC_STAGES = 2;

    // field positions of the configuration word carried into the link domain
    localparam int CFG_SER_RX_FS  = 0;
    localparam int CFG_SER_TX_FS  = 1;
    localparam int CFG_DIR_RX_FS  = 2;
    localparam int CFG_DIR_TX_FS  = 4;
    localparam int CFG_GOUT_RX_FS = 6;
    localparam int CFG_GOUT_TX_FS = 7;
    localparam int CFG_SYN        = 8;
    localparam int CFG_TX_EXT_BUFFER_ENABLE_SELECT       = 9;
    localparam int CFG_RX_FS_DIRECTION       = 10;
    localparam int CFG_TX_FS_DIRECTION       = 11;
    localparam int CFG_NETWORK    = 12;
    localparam int CFG_OF1        = 13;
    localparam int CFG_WIDTH      = 14;

    // function of the receiver frame-sync pin
    typedef enum logic [1:0] {
        ROLE_GPIO,
        ROLE_FS,
        ROLE_FLAG,
        ROLE_BUFEN
    } rx_fs_role_t;

endpackage

// file: design/level_sync.sv
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rst_n,
    // level from another domain or a pin
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// file: design/hf_clock_gen.sv
`timescale 1ns/1ns
module hf_clock_gen #(
    parameter int HALF = audio_pin_pkg::HF_HALF_DEF
) (
    // core clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // divided sample clock, registered
    output logic      clk_div_r
);

    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_r;

    initial begin
        if (HALF < 1) begin
            $error("hf_clock_gen: HALF must be at least 1");
        end
    end

    // free-running so the pin shows a clean clock the moment it is selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r     <= '0;
            clk_div_r <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r     <= '0;
            clk_div_r <= ~clk_div_r;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

endmodule

// file: bench/codec_model.sv
`timescale 1ns/1ns
// far-side converter: drives released lines or leaves them to the pulls
module codec_model (
    // link clock for the clash monitor
    input  wire logic       clk,
    // what the converter drives
    input  wire logic [3:0] codec_drive,
    input  wire logic [3:0] codec_level,
    // device pin drivers
    input  wire logic [3:0] dut_o,
    input  wire logic [3:0] dut_oe,
    // resolved pin levels and fault flag
    output logic      [3:0] pin_i,
    output logic            clash_seen
);
    // hf lines pulled up, frame-sync lines pulled down, so a released line never floats
    localparam logic [3:0] PULL = 4'h3;

    // wire level from every driver
    assign pin_i = (dut_oe & dut_o) | (~dut_oe & codec_drive & codec_level) | (~dut_oe & ~codec_drive & PULL);

    // two drivers on one line means the device picked two functions; sticky once seen
    always @(posedge clk) begin
        clash_seen <= (clash_seen === 1'b1) || (|(dut_oe & codec_drive));
    end
endmodule

// file: bench/audio_pin_ctrl_test.sv
`timescale 1ns/1ns
module audio_pin_ctrl_test;
    localparam int HF_HALF = 2;
    logic       clk_sys, rst_n, clk_link, hck_rx, hck_tx, sync_mode, bufen_sel, rx_dir, tx_dir, net_mode;
    logic       out_flag, in_flag, rx_from, tx_from, rx_fs_gen, tx_fs_gen, slot_start, buf_req;
    logic       rx_fs_recv, tx_fs_xmit, clash_seen;
    logic [3:0] pin_serial_sel, gpio_out, gpio_in, codec_drive, codec_level;
    logic [7:0] gpio_dir;
    wire  [3:0] pin_i, pin_o, pin_oe;
    int         num_errors, cmp_count;

    // pins 0..3: rx hf, tx hf, rx fs, tx fs
    audio_pin_ctrl #(.HF_HALF(HF_HALF)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
        .pin_serial_sel(pin_serial_sel), .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(gpio_in),
        .hck_rx_dir(hck_rx), .hck_tx_dir(hck_tx), .shared_clocking_select(sync_mode),
        .tx_ext_buffer_enable_select(bufen_sel), .rx_fs_direction(rx_dir), .tx_fs_direction(tx_dir),
        .network_mode(net_mode), .serial_out_flag_one(out_flag), .serial_in_flag_one(in_flag),
        .rx_clk_from_pin(rx_from), .tx_clk_from_pin(tx_from), .rx_fs_gen(rx_fs_gen), .tx_fs_gen(tx_fs_gen),
        .slot_start(slot_start), .tx_buf_en_req(buf_req), .rx_fs_recv(rx_fs_recv), .tx_fs_xmit(tx_fs_xmit),
        .rx_high_freq_clock_pin_i(pin_i[0]), .rx_high_freq_clock_pin_o(pin_o[0]),
        .rx_high_freq_clock_pin_oe(pin_oe[0]), .tx_high_freq_clock_pin_i(pin_i[1]),
        .tx_high_freq_clock_pin_o(pin_o[1]), .tx_high_freq_clock_pin_oe(pin_oe[1]),
        .rx_frame_sync_pin_i(pin_i[2]), .rx_frame_sync_pin_o(pin_o[2]), .rx_frame_sync_pin_oe(pin_oe[2]),
        .tx_frame_sync_pin_i(pin_i[3]), .tx_frame_sync_pin_o(pin_o[3]), .tx_frame_sync_pin_oe(pin_oe[3])
    );

    codec_model codec (
        .clk(clk_link), .codec_drive(codec_drive), .codec_level(codec_level),
        .dut_o(pin_o), .dut_oe(pin_oe), .pin_i(pin_i), .clash_seen(clash_seen)
    );

    // core clock 40 ns; link clock 6 ns with its own phase
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #1;
        forever #3 clk_link = ~clk_link;
    end

    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // long enough for 2-ff sync plus register in either domain
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    // m = sync, buffer-enable select, rx dir, tx dir, network, out flag
    task automatic cfg(input logic [3:0] sel, input logic [1:0] hd, input logic [5:0] m);
        @(posedge clk_sys);
        #1;
        pin_serial_sel = sel;
        {hck_tx, hck_rx} = hd;
        {sync_mode, bufen_sel, rx_dir, tx_dir, net_mode, out_flag} = m;
        settle();
    endtask

    // a few link clocks first so the pin level has crossed the synchroniser
    task automatic fs_pulse();
        repeat (4) @(posedge clk_link);
        #1 tx_fs_gen = 1'b1;
        repeat (4) @(posedge clk_link);
        #1 tx_fs_gen = 1'b0;
        settle();
    endtask

    task automatic slot_pulse();
        @(posedge clk_link);
        #1 slot_start = 1'b1;
        @(posedge clk_link);
        #1 slot_start = 1'b0;
        settle();
    endtask

    // count sample-clock edges on both hf pins over 8 core cycles
    task automatic hf_toggles(input logic [3:0] exp0, input logic [3:0] exp1);
        int         n0, n1;
        logic [1:0] prev;
        n0 = 0;
        n1 = 0;
        prev = pin_o[1:0];
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            n0 += int'(pin_o[0] !== prev[0]);
            n1 += int'(pin_o[1] !== prev[1]);
            prev = pin_o[1:0];
        end
        chk("rx hf edges", exp0, 4'(n0));
        chk("tx hf edges", exp1, 4'(n1));
    endtask

    task automatic t_hf();
        cfg(4'h3, 2'h1, 6'h00);
        chk("hf oe rx out", 4'h1, pin_oe);
        chk("tx clk from pin", 4'h1, {3'h0, tx_from});
        chk("rx clk from pin", 4'h0, {3'h0, rx_from});
        hf_toggles(4'(8 / HF_HALF), 4'h0);
        cfg(4'h3, 2'h2, 6'h00);
        chk("hf oe tx out", 4'h2, pin_oe);
        chk("rx clk from pin", 4'h1, {3'h0, rx_from});
        chk("tx clk from pin", 4'h0, {3'h0, tx_from});
        hf_toggles(4'h0, 4'(8 / HF_HALF));
    endtask

    // each pin alone: output, input, then disconnected while driven
    task automatic t_gpio();
        for (int p = 0; p < 4; p++) begin
            cfg(4'h0, 2'h0, 6'h00);
            gpio_dir = 8'h00;
            gpio_dir[2*p +: 2] = audio_pin_pkg::GPIO_OUT;
            gpio_out = 4'h1 << p;
            settle();
            chk("gpio out oe", 4'h1 << p, pin_oe);
            chk("gpio out level", 4'h1 << p, pin_o);
            gpio_dir[2*p +: 2] = audio_pin_pkg::GPIO_IN;
            settle();
            chk("gpio in pull", 4'h3 & (4'h1 << p), gpio_in);
            codec_drive = 4'h1 << p;
            codec_level = 4'h1 << p;
            settle();
            chk("gpio in oe", 4'h0, pin_oe);
            chk("gpio in level", 4'h1 << p, gpio_in);
            gpio_dir = 8'h00;
            settle();
            chk("gpio off level", 4'h0, gpio_in);
            codec_drive = 4'h0;
        end
    endtask

    task automatic t_async();
        cfg(4'hc, 2'h0, 6'b001100);
        rx_fs_gen = 1'b1;
        settle();
        chk("async oe", 4'hc, pin_oe);
        chk("async rx fs out", 4'h4, pin_o);
        chk("async fs paths", 4'h2, {2'h0, rx_fs_recv, tx_fs_xmit});
        rx_fs_gen = 1'b0;
        tx_fs_gen = 1'b1;
        settle();
        chk("async tx fs out", 4'h8, pin_o);
        chk("async fs paths", 4'h1, {2'h0, rx_fs_recv, tx_fs_xmit});
        tx_fs_gen = 1'b0;
        cfg(4'hc, 2'h0, 6'b000000);
        chk("async in oe", 4'h0, pin_oe);
        codec_drive = 4'hc;
        codec_level = 4'h4;
        settle();
        chk("async fs from pins", 4'h2, {2'h0, rx_fs_recv, tx_fs_xmit});
        codec_level = 4'h8;
        cfg(4'hc, 2'h0, 6'b100000);
        chk("sync shared fs", 4'h3, {2'h0, rx_fs_recv, tx_fs_xmit});
    endtask

    task automatic t_bufen();
        codec_drive = 4'h0;
        cfg(4'hc, 2'h0, 6'b111100);
        buf_req = 1'b1;
        settle();
        chk("bufen drive", 4'h4, pin_o & pin_oe);
        buf_req = 1'b0;
        settle();
        chk("bufen low", 4'hc, {pin_oe[3:2], pin_o[3:2]});
        cfg(4'hc, 2'h0, 6'b110100);
        chk("bufen off rx in", 4'h8, pin_oe);
    endtask

    // output flag waits for its frame or slot
    task automatic t_flag_out();
        cfg(4'hc, 2'h0, 6'b101101);
        chk("flag out oe", 4'hc, pin_oe);
        chk("flag before frame", 4'h0, pin_o);
        fs_pulse();
        chk("flag after frame", 4'h4, pin_o);
        cfg(4'hc, 2'h0, 6'b101110);
        fs_pulse();
        chk("net flag on frame", 4'h4, pin_o);
        slot_pulse();
        chk("net flag on slot", 4'h0, pin_o);
    endtask

    task automatic t_flag_in();
        cfg(4'hc, 2'h0, 6'b100100);
        chk("flag in oe", 4'h8, pin_oe);
        codec_drive = 4'h4;
        codec_level = 4'h4;
        fs_pulse();
        chk("in flag frame", 4'h1, {3'h0, in_flag});
        codec_level = 4'h0;
        settle();
        chk("in flag held", 4'h1, {3'h0, in_flag});
        fs_pulse();
        chk("in flag frame", 4'h0, {3'h0, in_flag});
        codec_level = 4'h4;
        cfg(4'hc, 2'h0, 6'b100110);
        fs_pulse();
        chk("net in flag frame", 4'h0, {3'h0, in_flag});
        slot_pulse();
        chk("net in flag slot", 4'h1, {3'h0, in_flag});
    endtask

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end

    // reset, then one scenario after another
    initial begin
        {rst_n, hck_rx, hck_tx, sync_mode, bufen_sel, rx_dir, tx_dir, net_mode, out_flag} = 9'h000;
        {rx_fs_gen, tx_fs_gen, slot_start, buf_req} = 4'h0;
        {pin_serial_sel, gpio_out, codec_drive, codec_level, gpio_dir} = 24'h000000;
        num_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("oe in reset", 4'h0, pin_oe);
        @(posedge clk_sys);
        #1 rst_n = 1'b1;
        settle();
        chk("oe after reset", 4'h0, pin_oe);
        chk("o after reset", 4'h0, pin_o);
        t_hf();
        t_gpio();
        t_async();
        t_bufen();
        t_flag_out();
        t_flag_in();
        chk("pin clash", 4'h0, {3'h0, clash_seen});
        complete_run();
    end
endmodule
